/* File: design/irap_top.sv */
// Operation
// - A frame is start, device address byte, three address bytes, three data bytes, stop.
// - Register address bytes arrive as bits 23:16, then 15:8, then 7:0.
// - Data bytes follow the address as bits 23:16, then 15:8, then 7:0.
// - Every byte written to the device up to the third data byte is acknowledged by pulling the data line low.
// - In normal operation the device answers to the address byte 0xB2.
// - Address bits 23:16 select an internal space and bits 15:0 the location in it.
// - Audio parameters live in the space whose upper address byte is zero.
// - Standard and fast bus timing are met and other masters may share the bus.
// - The device is only ever a bus slave and never starts a transfer.
// - With slave boot strapped, the device answers at 0x88 during the boot phase.
`timescale 1ns/10ps
`default_nettype none
module irap_top
   import irap_pkg::*;
(
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   // Two-wire bus pins
   input  wire logic              i_scl,
   input  wire logic              i_sda,
   output logic                   o_sda_out,
   output logic                   o_sda_oe_n,
   // Boot control
   input  wire logic              i_boot_slave,
   input  wire logic              i_boot_done,
   output logic                   o_boot_active,
   // Completed register writes toward the processor
   output logic                   o_wr_valid,
   output irap_pkg::irap_acc_t    o_wr
);
   import irap_pkg::*;

   irap_state_t state_r;
   logic        scl_s1_r, scl_s2_r, scl_d_r;
   logic        sda_s1_r, sda_s2_r, sda_d_r;
   logic        strap_s1_r, strap_s2_r;
   logic [1:0]  rel_r;
   logic        boot_r;
   logic [3:0]  bit_cnt_r;
   logic [2:0]  byte_idx_r;
   logic [1:0]  tx_idx_r;
   logic        rw_r;
   logic [7:0]  sh_r;
   logic [23:0] addr_r;
   logic [23:0] data_r;
   logic        oe_n_r;
   logic        sda_out_r;
   logic        wr_valid_r;
   irap_acc_t   wr_r;
   logic [23:0] mem_rdata;
   logic [23:0] rd_word;
   logic        scl_rise, scl_fall, start_det, stop_det;
   logic        rx_done, addr_hit, wr_fire, mem_we;
   logic [7:0]  own_addr;

   // Pin synchronisers plus one delay stage for edge detection
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_d_r  <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sda_d_r  <= 1'b1;
      end else begin
         scl_s1_r <= i_scl;
         scl_s2_r <= scl_s1_r;
         scl_d_r  <= scl_s2_r;
         sda_s1_r <= i_sda;
         sda_s2_r <= sda_s1_r;
         sda_d_r  <= sda_s2_r;
      end
   end

   // Bus events; sampling at 20 MHz leaves ample margin for fast mode
   assign scl_rise  = scl_s2_r & ~scl_d_r;
   assign scl_fall  = ~scl_s2_r & scl_d_r;
   assign start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
   assign stop_det  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
   assign rx_done   = (state_r == ST_RX) && scl_fall && (bit_cnt_r == BITS_PER_BYTE);

   // Strap is caught after reset release, never under the reset itself
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         strap_s1_r <= 1'b0;
         strap_s2_r <= 1'b0;
         rel_r      <= 2'h0;
         boot_r     <= 1'b0;
      end else begin
         strap_s1_r <= i_boot_slave;
         strap_s2_r <= strap_s1_r;
         // Counts to the third edge so the strap has crossed both sync stages
         rel_r      <= (rel_r == 2'h3) ? rel_r : rel_r + 2'h1;
         if (rel_r == 2'h2) begin
            boot_r <= strap_s2_r;
         end else if (i_boot_done) begin
            boot_r <= 1'b0;
         end
      end
   end

   // Own address follows the boot phase
   assign own_addr = boot_r ? ADDR_BYTE_BOOT : ADDR_BYTE_RUN;
   assign addr_hit = (sh_r[7:1] == own_addr[7:1]);

   // Read data come from the store only for the parameter space
   assign rd_word = irap_in_mem(addr_r) ? mem_rdata : WORD_ZERO;

   // Serial engine; stop or start from any master aborts our frame
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_r    <= ST_IDLE;
         bit_cnt_r  <= 4'h0;
         byte_idx_r <= 3'h0;
         tx_idx_r   <= 2'h0;
         rw_r       <= 1'b0;
         sh_r       <= 8'h00;
      end else if (stop_det) begin
         state_r <= ST_IDLE;
      end else if (start_det) begin
         // A repeated start keeps the address for the read phase
         state_r    <= ST_RX;
         bit_cnt_r  <= 4'h0;
         byte_idx_r <= BYTE_DEV;
      end else begin
         case (state_r)
            ST_RX: begin
               if (scl_rise) begin
                  sh_r      <= {sh_r[6:0], sda_s2_r};
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end else if (rx_done) begin
                  bit_cnt_r <= 4'h0;
                  if (byte_idx_r == BYTE_DEV) begin
                     // Foreign addresses get no acknowledge
                     state_r  <= addr_hit ? ST_ACK : ST_WAIT;
                     rw_r     <= sh_r[0];
                     tx_idx_r <= 2'h0;
                  end else if (byte_idx_r <= BYTE_DATA_LAST) begin
                     state_r <= ST_ACK;
                  end else begin
                     state_r <= ST_WAIT;
                  end
                  byte_idx_r <= byte_idx_r + 3'h1;
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  state_r <= rw_r ? ST_TX : ST_RX;
                  sh_r    <= irap_byte_sel(rd_word, tx_idx_r);
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (bit_cnt_r == TX_BIT_LAST) begin
                     state_r   <= ST_RACK;
                     bit_cnt_r <= 4'h0;
                  end else begin
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end
                  sh_r <= {sh_r[6:0], 1'b1};
               end
            end
            ST_RACK: begin
               // Refusal or the third byte ends our part of the read
               if (scl_rise) begin
                  if (sda_s2_r || (tx_idx_r == TX_BYTE_LAST)) begin
                     state_r <= ST_WAIT;
                  end else begin
                     state_r  <= ST_NEXT;
                     tx_idx_r <= tx_idx_r + 2'h1;
                  end
               end
            end
            ST_NEXT: begin
               if (scl_fall) begin
                  state_r <= ST_TX;
                  sh_r    <= irap_byte_sel(rd_word, tx_idx_r);
               end
            end
            ST_IDLE, ST_WAIT: begin
               state_r <= state_r;
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Address and data bytes, most significant first
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         addr_r <= WORD_ZERO;
         data_r <= WORD_ZERO;
      end else if (rx_done && (byte_idx_r != BYTE_DEV)) begin
         if (byte_idx_r <= BYTE_ADDR_LAST) begin
            addr_r <= {addr_r[15:0], sh_r};
         end else begin
            data_r <= {data_r[15:0], sh_r};
         end
      end
   end

   // Write completes on the last data byte of a write frame
   assign wr_fire = rx_done && (byte_idx_r == BYTE_DATA_LAST) && !rw_r;
   assign mem_we  = wr_fire && irap_in_mem(addr_r);

   // Outgoing write strobe; other spaces go to the processor only
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wr_valid_r <= 1'b0;
         wr_r       <= '0;
      end else begin
         wr_valid_r <= wr_fire;
         if (wr_fire) begin
            wr_r <= '{space: addr_r[23:16], loc: addr_r[15:0], data: {data_r[15:0], sh_r}};
         end
      end
   end

   // Data line driver; clock line is never driven, the master owns it
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         oe_n_r    <= 1'b1;
         sda_out_r <= 1'b0;
      end else begin
         oe_n_r    <= ~((state_r == ST_ACK) || ((state_r == ST_TX) && !sh_r[7]));
         sda_out_r <= 1'b0;
      end
   end

   irap_mem u_mem (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_we    (mem_we),
      .i_waddr (addr_r[MEM_AW-1:0]),
      .i_wdata ({data_r[15:0], sh_r}),
      .i_raddr (addr_r[MEM_AW-1:0]),
      .o_rdata (mem_rdata)
   );

   assign o_sda_out     = sda_out_r;
   assign o_sda_oe_n    = oe_n_r;
   assign o_boot_active = boot_r;
   assign o_wr_valid    = wr_valid_r;
   assign o_wr          = wr_r;

   // Checks
   a_ack_drive_low: assert property (@(posedge i_clk) disable iff (i_rst)
      (state_r == ST_ACK) |=> !o_sda_oe_n) else $error("ack bit not driven low");
   a_foreign_no_ack: assert property (@(posedge i_clk) disable iff (i_rst)
      (rx_done && byte_idx_r == BYTE_DEV && sh_r[7:1] != own_addr[7:1] && !stop_det
       && !start_det) |=> (state_r == ST_WAIT) ##1 o_sda_oe_n)
      else $error("foreign address acknowledged");
   a_run_addr_ack: assert property (@(posedge i_clk) disable iff (i_rst)
      (rx_done && byte_idx_r == BYTE_DEV && !boot_r && sh_r[7:1] == ADDR_BYTE_RUN[7:1]
       && !stop_det && !start_det) |=> (state_r == ST_ACK) ##1 !o_sda_oe_n)
      else $error("run address not acknowledged");
   a_boot_addr_ack: assert property (@(posedge i_clk) disable iff (i_rst)
      (rx_done && byte_idx_r == BYTE_DEV && boot_r && sh_r[7:1] == ADDR_BYTE_BOOT[7:1]
       && !stop_det && !start_det) |=> (state_r == ST_ACK))
      else $error("boot address not acknowledged");
   a_addr_byte_order: assert property (@(posedge i_clk) disable iff (i_rst)
      (rx_done && byte_idx_r == BYTE_ADDR_LAST) |=> addr_r[7:0] == $past(sh_r)
      && addr_r[23:8] == $past(addr_r[15:0])) else $error("address byte order wrong");
   a_data_byte_order: assert property (@(posedge i_clk) disable iff (i_rst)
      wr_fire |=> o_wr_valid && o_wr.data == {$past(data_r[15:0]), $past(sh_r)})
      else $error("data byte order wrong");
   a_param_space: assert property (@(posedge i_clk) disable iff (i_rst)
      wr_fire |-> mem_we == (addr_r[23:16] == SPACE_PARAM && addr_r[15:MEM_AW] == '0))
      else $error("parameter space decode wrong");
   a_space_split: assert property (@(posedge i_clk) disable iff (i_rst)
      wr_fire |=> o_wr.space == $past(addr_r[23:16]) && o_wr.loc == $past(addr_r[15:0]))
      else $error("space or location field wrong");
   a_frame_length: assert property (@(posedge i_clk) disable iff (i_rst)
      o_wr_valid |-> $past(byte_idx_r) == BYTE_DATA_LAST && !$past(rw_r))
      else $error("write outside a full frame");
   a_slave_drive: assert property (@(posedge i_clk) disable iff (i_rst)
      !o_sda_oe_n |-> !o_sda_out && ($past(state_r) == ST_ACK || $past(state_r) == ST_TX))
      else $error("data line driven outside slave slots");
   a_stop_release: assert property (@(posedge i_clk) disable iff (i_rst)
      stop_det |=> (state_r == ST_IDLE) ##1 o_sda_oe_n)
      else $error("bus not released after stop");
endmodule : irap_top
`default_nettype wire

/* File: design/irap_pkg.sv */
`default_nettype none
package irap_pkg;
   // Bus device address bytes, write direction in bit 0
   localparam logic [7:0]  ADDR_BYTE_RUN  = 8'hB2;
   localparam logic [7:0]  ADDR_BYTE_BOOT = 8'h88;
   // Address space that carries the audio parameters
   localparam logic [7:0]  SPACE_PARAM    = 8'h00;
   // Parameter store depth, in address bits of the location field
   localparam int          MEM_AW         = 8;
   localparam logic [23:0] WORD_ZERO      = 24'h00_0000;
   // Byte positions inside one frame
   localparam logic [2:0]  BYTE_DEV       = 3'h0;
   localparam logic [2:0]  BYTE_ADDR_LAST = 3'h3;
   localparam logic [2:0]  BYTE_DATA_LAST = 3'h6;
   localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
   localparam logic [3:0]  TX_BIT_LAST    = 4'h7;
   localparam logic [1:0]  TX_BYTE_LAST   = 2'h2;

   // One register access handed to the processor side
   typedef struct packed {
      logic [7:0]  space;
      logic [15:0] loc;
      logic [23:0] data;
   } irap_acc_t;

   // Serial engine states, one-hot
   typedef enum logic [6:0] {
      ST_IDLE = 7'b000_0001,
      ST_RX   = 7'b000_0010,
      ST_ACK  = 7'b000_0100,
      ST_TX   = 7'b000_1000,
      ST_RACK = 7'b001_0000,
      ST_NEXT = 7'b010_0000,
      ST_WAIT = 7'b100_0000
   } irap_state_t;

   // True when a register address lands in the local parameter store
   function automatic logic irap_in_mem(input logic [23:0] addr);
      irap_in_mem = (addr[23:16] == SPACE_PARAM) && (addr[15:MEM_AW] == '0);
   endfunction : irap_in_mem

   // Picks data byte 0 (bits 23:16), 1 or 2 of a word
   function automatic logic [7:0] irap_byte_sel(input logic [23:0] w, input logic [1:0] idx);
      case (idx)
         2'h0:    irap_byte_sel = w[23:16];
         2'h1:    irap_byte_sel = w[15:8];
         default: irap_byte_sel = w[7:0];
      endcase
   endfunction : irap_byte_sel
endpackage : irap_pkg
`default_nettype wire

/* File: design/irap_mem.sv */
`timescale 1ns/10ps
`default_nettype none
module irap_mem
   import irap_pkg::*;
(
   // Clock and reset
   input  wire logic                i_clk,
   input  wire logic                i_rst,
   // Write port
   input  wire logic                i_we,
   input  wire logic [MEM_AW-1:0]   i_waddr,
   input  wire logic [23:0]         i_wdata,
   // Read port, data one cycle after the address
   input  wire logic [MEM_AW-1:0]   i_raddr,
   output logic      [23:0]         o_rdata
);
   logic [23:0] mem [0:(1<<MEM_AW)-1];
   logic [23:0] rdata_r;

   // Array has no reset so it maps onto plain RAM
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end

   // Registered read
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rdata_r <= WORD_ZERO;
      end else begin
         rdata_r <= mem[i_raddr];
      end
   end

   assign o_rdata = rdata_r;
endmodule : irap_mem
`default_nettype wire

/* File: dv/irap_master.sv */
`timescale 1ns/10ps
`default_nettype none
// Bus master model: it owns SCL and an open-drain pull on SDA
module irap_master (
   // Clock and the resolved data wire
   input  wire logic i_clk,
   input  wire logic i_sda,
   // Master drive, o_sda_rel high leaves the line to its pull-up
   output logic      o_scl,
   output logic      o_sda_rel
);
   // Both lines idle high
   initial begin
      o_scl     = 1'b1;
      o_sda_rel = 1'b1;
   end
   // Clocks a phase; 8 gives fast timing, the bench raises it for standard speed
   int gap_n = 8;
   task automatic gap();
      repeat (gap_n) @(posedge i_clk);
   endtask : gap
   // Start, also a repeated start from SCL low
   task automatic start();
      o_sda_rel <= 1'b1;
      gap();
      o_scl <= 1'b1;
      gap();
      o_sda_rel <= 1'b0;
      gap();
      o_scl <= 1'b0;
      gap();
   endtask : start
   // Stop closes every frame
   task automatic stop();
      o_sda_rel <= 1'b0;
      gap();
      o_scl <= 1'b1;
      gap();
      o_sda_rel <= 1'b1;
      gap();
   endtask : stop
   // One bit: set while SCL low, read in mid high phase
   task automatic bit_io(input logic b, output logic r);
      o_sda_rel <= b;
      gap();
      o_scl <= 1'b1;
      repeat (4) @(posedge i_clk);
      #1 r = i_sda;
      repeat (4) @(posedge i_clk);
      o_scl <= 1'b0;
   endtask : bit_io
   // Byte MSB first, then the ninth bit for the ack
   task automatic byte_io(input logic [7:0] w, input logic mack,
                          output logic [7:0] rd, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(w[i], rd[i]);
      end
      bit_io(mack, ack);
   endtask : byte_io
endmodule : irap_master
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
   $display("BAD t=%0t got %h expected %h", $time, (a), (b)); end end
module tb_top;
   import irap_pkg::*;
   logic        clk, rst, boot, done, rel, scl, oe_n, sda_o, bact, wv;
   wire         sda_w;
   irap_acc_t   wr;
   irap_acc_t   q[$];
   irap_acc_t   acc;
   int          n_mismatch = 0;
   int          num_checks = 0;
   int          mdl[int];
   logic [31:0] seed = 32'h0000_003E;
   logic [7:0]  rb;
   logic        ak;
   logic [23:0] ad[6];
   logic [23:0] dt[6];
   logic [23:0] got;
   // Wire level: pull-up unless either party pulls low
   assign sda_w = rel & (oe_n | sda_o);
   irap_master u_mst (.i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda_rel(rel));
   irap_top u_dut (.i_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda_w),
      .o_sda_out(sda_o), .o_sda_oe_n(oe_n), .i_boot_slave(boot), .i_boot_done(done),
      .o_boot_active(bact), .o_wr_valid(wv), .o_wr(wr));
   // Clock, 50 ns period
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Collect every completed write
   always @(posedge clk) begin
      if (wv === 1'b1) q.push_back(wr);
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : conclude
   // Reset, then stay off the bus until the port is ready
   task automatic do_reset(input logic b);
      boot <= b;
      rst  <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
   endtask : do_reset
   // Write a byte and compare the ack bit with the expectation
   task automatic send(input logic [7:0] b, input logic acked);
      u_mst.byte_io(b, 1'b1, rb, ak);
      `CHK(ak, ~acked)
   endtask : send
   task automatic put_addr(input logic [23:0] a);
      u_mst.start();
      send(ADDR_BYTE_RUN, 1'b1);
      for (int i = 2; i >= 0; i--) send(a[i*8 +: 8], 1'b1);
   endtask : put_addr
   // Write frame with n data bytes; bytes past the third wrap and get no ack
   task automatic wr_frame(input logic [23:0] a, input logic [23:0] d, input int n);
      put_addr(a);
      for (int i = 0; i < n; i++) send(d[23-(i%3)*8 -: 8], i < 3);
      u_mst.stop();
      repeat (2) @(posedge clk);
      if (n >= 3 && a[23:8] == 16'h0000) mdl[a] = d;
      `CHK(q.size(), (n >= 3) ? 1 : 0)
      if (n >= 3 && q.size() > 0) begin
         acc = q.pop_front();
         `CHK(acc, {a, d})
      end
   endtask : wr_frame
   // Dummy write, repeated start, three bytes with ACK ACK NACK
   task automatic rd_frame(input logic [23:0] a, output logic [23:0] d);
      put_addr(a);
      u_mst.start();
      send(ADDR_BYTE_RUN | 8'h01, 1'b1);
      for (int i = 0; i < 3; i++) begin
         u_mst.byte_io(8'hFF, (i == 2), rb, ak);
         d[23-i*8 -: 8] = rb;
      end
      u_mst.stop();
   endtask : rd_frame
   // Watchdog for a hung bus
   initial begin
      repeat (80000) @(posedge clk);
      n_mismatch++;
      conclude();
   end
   initial begin
      rst  = 1'b1;
      boot = 1'b0;
      done = 1'b0;
      do_reset(1'b0);
      // Parameter space writes, the rest spill to other spaces
      for (int i = 0; i < 6; i++) begin
         ad[i] = (i < 4) ? {16'h0000, 8'(xs())} : {8'(xs()), 16'h0100};
         dt[i] = 24'(xs());
         wr_frame(ad[i], dt[i], 3);
      end
      ad[5][23:16] = 8'h00; // Space zero, location above the store
      wr_frame(ad[5], dt[5], 3);
      for (int i = 0; i < 6; i++) begin
         rd_frame(ad[i], got);
         `CHK(got, mdl.exists(ad[i]) ? mdl[ad[i]] : 0)
      end
      // Short frame, over-long frame, then a foreign address
      wr_frame(24'h00_0001, 24'hAB_CDEF, 2);
      rd_frame(24'h00_0001, got);
      `CHK(got, mdl.exists(1) ? mdl[1] : 0)
      wr_frame(24'h00_0003, 24'(xs()), 4);
      rd_frame(24'h00_0003, got);
      `CHK(got, mdl[3])
      u_mst.start();
      send(8'hA0, 1'b0);
      send(8'h00, 1'b0);
      u_mst.stop();
      `CHK(q.size(), 0)
      // Slave boot phase answers only at its boot address
      do_reset(1'b1);
      `CHK(bact, 1'b1)
      u_mst.start();
      send(ADDR_BYTE_RUN, 1'b0);
      u_mst.start();
      send(ADDR_BYTE_BOOT, 1'b1);
      u_mst.stop();
      @(posedge clk);
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK(bact, 1'b0)
      // Standard-speed gap phases for the last frames; each bit's SCL high phase stays 8 clocks
      u_mst.gap_n = 40;
      wr_frame(24'h00_0002, 24'h12_3456, 3);
      rd_frame(24'h00_0002, got);
      `CHK(got, 24'h12_3456)
      conclude();
   end
endmodule : tb_top
`default_nettype wire
